// file: vic_pkg.sv
// Constants, types and register map of the vectored interrupt controller
package vic_pkg;

	localparam int NUM_SRC = 118;
	localparam int NUM_TRAP = 8;
	localparam int NUM_VEC = 126;
	localparam int ADDR_W = 12;
	localparam int TABLE_AW = 8;

	// Program word addresses of the vector tables and of reset entry
	localparam logic [23:0] PRI_TABLE_BASE = 24'h000004;
	localparam logic [23:0] ALT_TABLE_BASE = 24'h000104;
	localparam logic [23:0] RESET_ADDR = 24'h000000;

	// Implemented interrupt sources and traps
	localparam logic [127:0] SRC_IMPL_MASK =
		128'h0000_0000_0000_2102_0000_0000_201F_BF8F;
	localparam logic [7:0] TRAP_IMPL_MASK = 8'h1E;
	localparam logic [3:0] TRAP_LEVEL = 4'h8;

	// Register offsets (byte addresses)
	localparam logic [11:0] FLAG_OFS = 12'h000;
	localparam logic [11:0] ENABLE_OFS = 12'h040;
	localparam logic [11:0] PRIO_OFS = 12'h080;
	localparam logic [11:0] LEVEL_OFS = 12'h100;
	localparam logic [11:0] LATCH_OFS = 12'h104;
	localparam logic [11:0] TRAP_OFS = 12'h108;
	localparam logic [11:0] TABSEL_OFS = 12'h10C;
	localparam logic [11:0] EVT_STAT_OFS = 12'h110;
	localparam logic [11:0] EVT_MASK_OFS = 12'h114;
	localparam logic [11:0] TABLE_OFS = 12'h400;
	localparam int FLAG_WORDS = 8;
	localparam int PRIO_WORDS = 32;
	localparam int TABLE_WORDS = 256;

	// Field positions
	localparam int LATCH_LVL_LSB = 8;
	localparam int TABSEL_BIT = 0;
	localparam int EVT_ENTRY = 0;
	localparam int EVT_TRAP = 1;
	localparam int EVT_RET = 2;

	// Reset values and responses
	localparam logic [3:0] LEVEL_RST = 4'h0;
	localparam logic [2:0] EVT_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Fixed latencies in clock cycles
	localparam int ENTRY_CYCLES = 2;
	localparam int RET_CYCLES = 1;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READ = 4'b0010,
		ST_GIVE = 4'b0100,
		ST_RET = 4'b1000
	} state_type;

	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} axil_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_type;

endpackage : vic_pkg

// file: vector_store.sv
// Vector table memory with registered read data
`timescale 1ns/100ps
module vector_store
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic we_i,
	input wire logic [vic_pkg::TABLE_AW-1:0] waddr_i,
	input wire logic [23:0] wdata_i,
	input wire logic [vic_pkg::TABLE_AW-1:0] raddr_i,
	output logic [23:0] rdata_o
);
	import vic_pkg::*;

	logic [23:0] mem_q [TABLE_WORDS];

	// Each entry holds one 24-bit service routine address
	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem_q[waddr_i] <= wdata_i;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rdata_o <= 24'h000000;
		else
			rdata_o <= mem_q[raddr_i];
	end

endmodule : vector_store

// file: vic_core.sv
// Vectored interrupt controller with AXI4-Lite register access
// Notes on behaviour
// - All source and trap requests merge into one CPU request line.
// - Each source has a 3-bit priority field, levels 1 to 7, 0 is off.
// - The primary table starts at word 000004h and holds 126 entries.
// - Eight trap entries come first, then up to 118 source entries.
// - Each entry is a 24-bit service routine address given to the CPU.
// - Every source and trap owns its own table entry.
// - At equal level the lower vector number wins.
// - Entry and return take a fixed number of cycles.
// - Reset bypasses the controller, clears state, entry is 000000h.
// - Trap k sits at 000004h+2k, alternate copy at 000104h+2k.
// - Source n sits at 000014h+2n, alternate copy at 000114h+2n.
// - Source n uses flag/enable bit n mod 16 of word n/16, field n mod 4.
// - A flag is set by its source and stays until software clears it.
// - A flagged source requests only while its enable bit is set.
// - On acceptance the vector number and new level are latched.
// - The CPU level is 4 bits and software cannot write its top bit.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module vic_core
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire vic_pkg::axil_req_type bus_i,
	output vic_pkg::axil_rsp_type bus_o,
	input wire logic [vic_pkg::NUM_SRC-1:0] src_i,
	input wire logic [vic_pkg::NUM_TRAP-1:0] trap_i,
	input wire logic cpu_ack_i,
	input wire logic cpu_ret_i,
	input wire logic [3:0] cpu_ret_level_i,
	output logic cpu_req_o,
	output logic vec_valid_o,
	output logic [23:0] vec_addr_o,
	output logic [23:0] vec_loc_o,
	output logic [6:0] vec_num_o,
	output logic [3:0] cpu_level_o,
	output logic ret_done_o,
	output logic irq_o
);
	import vic_pkg::*;

	state_type state_q;
	logic flag_q [NUM_SRC];
	logic en_q [NUM_SRC];
	logic [2:0] prio_q [NUM_SRC];
	wire [127:0] flag_vec;
	wire [127:0] en_vec;
	wire [511:0] prio_vec;
	logic [NUM_SRC-1:0] elig;
	logic [7:0] trap_q;
	logic [3:0] lvl_q;
	logic [6:0] vnum_q;
	logic [3:0] nlvl_q;
	logic alt_q;
	logic [2:0] evt_q;
	logic [2:0] emask_q;
	logic [23:0] loc_q;
	logic best_ok;
	logic [6:0] best_idx;
	logic [3:0] best_lvl;
	logic take;
	logic ret_take;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] wr_flag;
	logic [7:0] wr_en;
	logic [31:0] wr_prio;
	logic wr_lvl;
	logic wr_trap;
	logic wr_alt;
	logic wr_evt;
	logic wr_emask;
	logic wr_tab;
	logic wr_ok;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [11:0] wa;
	logic [11:0] ra;
	logic [31:0] wd;
	logic [3:0] ws;

	function automatic logic in_range(input logic [11:0] a,
		input logic [11:0] base, input int words);
		return (a >= base) && ({20'h0, a} < {20'h0, base} + 32'(words * 4))
			&& (a[1:0] == 2'b00);
	endfunction : in_range

	function automatic logic [6:0] word_of(input logic [11:0] a,
		input logic [11:0] base);
		return 7'((a - base) >> 2);
	endfunction : word_of

	assign wa = bus_i.awaddr;
	assign ra = bus_i.araddr;
	assign wd = bus_i.wdata;
	assign ws = bus_i.wstrb;

	// Bus handshakes
	assign wr_fire = bus_i.awvalid && bus_i.wvalid && !bvalid_q;
	assign rd_fire = bus_i.arvalid && !rvalid_q;
	always_comb
	begin
		bus_o.awready = wr_fire;
		bus_o.wready = wr_fire;
		bus_o.bvalid = bvalid_q;
		bus_o.bresp = bresp_q;
		bus_o.arready = !rvalid_q;
		bus_o.rvalid = rvalid_q;
		bus_o.rdata = rdata_q;
		bus_o.rresp = rresp_q;
	end

	// Write decode
	always_comb
	begin
		wr_flag = '0;
		wr_en = '0;
		wr_prio = '0;
		wr_lvl = 1'b0;
		wr_trap = 1'b0;
		wr_alt = 1'b0;
		wr_evt = 1'b0;
		wr_emask = 1'b0;
		wr_tab = 1'b0;
		wr_ok = 1'b1;
		if (wr_fire)
		begin
			if (in_range(wa, FLAG_OFS, FLAG_WORDS))
				wr_flag[3'(word_of(wa, FLAG_OFS))] = 1'b1;
			else if (in_range(wa, ENABLE_OFS, FLAG_WORDS))
				wr_en[3'(word_of(wa, ENABLE_OFS))] = 1'b1;
			else if (in_range(wa, PRIO_OFS, PRIO_WORDS))
				wr_prio[5'(word_of(wa, PRIO_OFS))] = 1'b1;
			else if (wa == LEVEL_OFS)
				wr_lvl = ws[0];
			else if (wa == TRAP_OFS)
				wr_trap = ws[0];
			else if (wa == TABSEL_OFS)
				wr_alt = ws[0];
			else if (wa == EVT_STAT_OFS)
				wr_evt = ws[0];
			else if (wa == EVT_MASK_OFS)
				wr_emask = ws[0];
			else if (in_range(wa, TABLE_OFS, TABLE_WORDS))
				wr_tab = &ws[2:0];
			else if (wa != LATCH_OFS)
				wr_ok = 1'b0;
		end
	end

	// Per-source flag, enable and priority storage
	for (genvar n = 0; n < NUM_SRC; n++)
	begin : g_src
		localparam int W = n / 16;
		localparam int B = n % 16;
		localparam int P = n / 4;
		localparam int F = n % 4;

		always_ff @(posedge clk_i or negedge nrst_i)
		begin
			if (!nrst_i)
				flag_q[n] <= 1'b0;
			else
				flag_q[n] <= SRC_IMPL_MASK[n] & (src_i[n] |
					((wr_flag[W] && ws[B / 8]) ? wd[B] : flag_q[n]));
		end

		always_ff @(posedge clk_i or negedge nrst_i)
		begin
			if (!nrst_i)
				en_q[n] <= 1'b0;
			else if (wr_en[W] && ws[B / 8])
				en_q[n] <= SRC_IMPL_MASK[n] & wd[B];
		end

		always_ff @(posedge clk_i or negedge nrst_i)
		begin
			if (!nrst_i)
				prio_q[n] <= 3'h0;
			else if (wr_prio[P] && ws[F / 2] && SRC_IMPL_MASK[n])
				prio_q[n] <= wd[F * 4 +: 3];
		end

		assign flag_vec[n] = flag_q[n];
		assign en_vec[n] = en_q[n];
		assign prio_vec[n * 4 +: 4] = {1'b0, prio_q[n]};
		assign elig[n] = flag_q[n] && en_q[n] &&
			({1'b0, prio_q[n]} > lvl_q);
	end
	assign flag_vec[127:NUM_SRC] = '0;
	assign en_vec[127:NUM_SRC] = '0;
	assign prio_vec[511:NUM_SRC * 4] = '0;

	// Arbitration: level first, then lowest vector number, traps above all
	always_comb
	begin
		best_ok = 1'b0;
		best_idx = 7'h00;
		best_lvl = 4'h0;
		for (int n = NUM_SRC - 1; n >= 0; n--)
		begin
			if (elig[n] && ({1'b0, prio_q[n]} >= best_lvl))
			begin
				best_ok = 1'b1;
				best_idx = 7'(n + NUM_TRAP);
				best_lvl = {1'b0, prio_q[n]};
			end
		end
		for (int i = NUM_TRAP - 1; i >= 0; i--)
		begin
			if (trap_q[i] && (lvl_q < TRAP_LEVEL))
			begin
				best_ok = 1'b1;
				best_idx = 7'(i);
				best_lvl = TRAP_LEVEL;
			end
		end
	end

	assign cpu_req_o = (state_q == ST_IDLE) && best_ok;
	assign take = cpu_req_o && cpu_ack_i;
	assign ret_take = (state_q == ST_IDLE) && cpu_ret_i && !take;

	// Entry and return sequencing, fixed length
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state_q <= ST_IDLE;
		else
		begin
			case (state_q)
				ST_IDLE:
					if (take)
						state_q <= ST_READ;
					else if (ret_take)
						state_q <= ST_RET;
				ST_READ:
					state_q <= ST_GIVE;
				ST_GIVE:
					state_q <= ST_IDLE;
				ST_RET:
					state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Vector latch and table location
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			vnum_q <= 7'h00;
			nlvl_q <= LEVEL_RST;
			loc_q <= RESET_ADDR;
		end
		else if (take)
		begin
			vnum_q <= best_idx;
			nlvl_q <= best_lvl;
			loc_q <= (alt_q ? ALT_TABLE_BASE : PRI_TABLE_BASE) +
				{16'h0000, best_idx, 1'b0};
		end
	end

	// CPU priority level
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			lvl_q <= LEVEL_RST;
		else if (take)
			lvl_q <= best_lvl;
		else if (ret_take)
			lvl_q <= cpu_ret_level_i;
		else if (wr_lvl)
			lvl_q[2:0] <= wd[2:0];
	end

	// Trap status, set wins over software write
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			trap_q <= 8'h00;
		else
			trap_q <= TRAP_IMPL_MASK & (trap_i |
				(wr_trap ? wd[7:0] : trap_q));
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			alt_q <= 1'b0;
		else if (wr_alt)
			alt_q <= wd[TABSEL_BIT];
	end

	// Event status, write one to clear, set wins
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			evt_q <= EVT_RST;
		else
		begin
			evt_q[EVT_ENTRY] <= take ||
				(evt_q[EVT_ENTRY] && !(wr_evt && wd[EVT_ENTRY]));
			evt_q[EVT_TRAP] <= (|(trap_i & TRAP_IMPL_MASK)) ||
				(evt_q[EVT_TRAP] && !(wr_evt && wd[EVT_TRAP]));
			evt_q[EVT_RET] <= ret_take ||
				(evt_q[EVT_RET] && !(wr_evt && wd[EVT_RET]));
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			emask_q <= EVT_RST;
		else if (wr_emask)
			emask_q <= wd[2:0];
	end

	assign irq_o = |(evt_q & emask_q);

	// Read decode
	always_comb
	begin
		rd_data = 32'h00000000;
		rd_ok = 1'b1;
		if (in_range(ra, FLAG_OFS, FLAG_WORDS))
			rd_data[15:0] = flag_vec[word_of(ra, FLAG_OFS) * 16 +: 16];
		else if (in_range(ra, ENABLE_OFS, FLAG_WORDS))
			rd_data[15:0] = en_vec[word_of(ra, ENABLE_OFS) * 16 +: 16];
		else if (in_range(ra, PRIO_OFS, PRIO_WORDS))
			rd_data[15:0] = prio_vec[word_of(ra, PRIO_OFS) * 16 +: 16];
		else if (ra == LEVEL_OFS)
			rd_data[3:0] = lvl_q;
		else if (ra == LATCH_OFS)
			rd_data = {20'h00000, nlvl_q, 1'b0, vnum_q};
		else if (ra == TRAP_OFS)
			rd_data[7:0] = trap_q;
		else if (ra == TABSEL_OFS)
			rd_data[TABSEL_BIT] = alt_q;
		else if (ra == EVT_STAT_OFS)
			rd_data[2:0] = evt_q;
		else if (ra == EVT_MASK_OFS)
			rd_data[2:0] = emask_q;
		else if (!in_range(ra, TABLE_OFS, TABLE_WORDS))
			rd_ok = 1'b0;
	end

	// Bus responses
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bus_i.bready)
			bvalid_q <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bus_i.rready)
			rvalid_q <= 1'b0;
	end

	vector_store u_store
	(
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.we_i(wr_tab),
		.waddr_i(wa[9:2]),
		.wdata_i(wd[23:0]),
		.raddr_i({alt_q, vnum_q}),
		.rdata_o(vec_addr_o)
	);

	assign vec_valid_o = (state_q == ST_GIVE);
	assign vec_loc_o = loc_q;
	assign vec_num_o = vnum_q;
	assign cpu_level_o = lvl_q;
	assign ret_done_o = (state_q == ST_RET);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_take;
		(state_q == ST_IDLE) && cpu_req_o && cpu_ack_i;
	endsequence

	sequence s_give;
		!vec_valid_o ##1 vec_valid_o;
	endsequence

	AST_ENTRY_LATENCY: assert property (s_take |=> s_give)
		else $error("vector not given two cycles after acceptance");

	AST_RET_LATENCY: assert property (
		ret_take |=> ret_done_o ##1 !ret_done_o)
		else $error("return not completed in one cycle");

	AST_LATCH: assert property (s_take |=>
		(vec_num_o == $past(best_idx)) && (cpu_level_o == $past(best_lvl)))
		else $error("vector number or level not latched");

	AST_TRAP_FIRST: assert property (
		((state_q == ST_IDLE) && (|trap_q) && (lvl_q < TRAP_LEVEL))
		|-> cpu_req_o && (best_idx < 7'd8))
		else $error("pending trap did not win arbitration");

	AST_LOC: assert property (vec_valid_o |->
		vec_loc_o == ($past(alt_q, 2) ? ALT_TABLE_BASE : PRI_TABLE_BASE)
		+ {16'h0000, vec_num_o, 1'b0})
		else $error("table location does not match vector number");

	AST_QUIET: assert property (
		((en_vec == '0) && (trap_q == '0)) |-> !cpu_req_o)
		else $error("request raised with nothing enabled");

	AST_LEVEL_TOP: assert property (
		(wr_lvl && !take && !ret_take) |=> lvl_q[3] == $past(lvl_q[3]))
		else $error("software changed the top level bit");

	AST_FLAG_HOLD: assert property ((wr_flag == '0) |=>
		((flag_vec & $past(flag_vec)) == $past(flag_vec)))
		else $error("flag cleared without a software write");

	AST_REQ_ABOVE: assert property (cpu_req_o |-> best_lvl > lvl_q)
		else $error("request not above the CPU level");

endmodule : vic_core

// file: cpu_model.sv
// CPU side model: takes requests and issues returns
`timescale 1ns/100ps
module cpu_model
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic req_i,
	input wire logic ack_en_i,
	input wire logic [3:0] delay_i,
	input wire logic ret_go_i,
	input wire logic [3:0] ret_level_i,
	output logic ack_o,
	output logic ret_o,
	output logic [3:0] ret_level_o
);
	logic [3:0] wait_q;
	logic arm;
	assign arm = req_i && ack_en_i && !ack_o;
	// Acknowledge pulse after a chosen wait while the request stands
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wait_q <= 4'h0;
			ack_o <= 1'b0;
		end
		else
		begin
			ack_o <= arm && (wait_q >= delay_i);
			wait_q <= arm ? wait_q + 4'h1 : 4'h0;
		end
	end
	// Return pulse; level toggles when not qualified
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ret_o <= 1'b0;
			ret_level_o <= 4'h0;
		end
		else
		begin
			ret_o <= ret_go_i;
			ret_level_o <= ret_go_i ? ret_level_i : ~ret_level_o;
		end
	end
endmodule : cpu_model

// file: vectored_interrupt_controller_test.sv
// Self-checking testbench of the vectored interrupt controller
`timescale 1ns/100ps
module vectored_interrupt_controller_test;
	import vic_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	axil_req_type bus_q = '0;
	axil_rsp_type bus_o;
	logic [NUM_SRC-1:0] src_q = '0;
	logic [NUM_TRAP-1:0] trap_q = '0;
	logic ack_en_q = 1'b0;
	logic go_q = 1'b0;
	logic [3:0] lvl_q = 4'h0;
	logic [3:0] dly_q = 4'h0;
	logic ack, ret, req, vvalid, rdone, irq;
	logic [3:0] ret_lvl, level;
	logic [23:0] vaddr, vloc;
	logic [6:0] vnum;
	logic [31:0] rd;
	logic [1:0] rsp;
	int miscompares = 0;
	int compares = 0;

	always #2 clk_i = ~clk_i;

	vic_core i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus_q),
		.bus_o(bus_o), .src_i(src_q), .trap_i(trap_q), .cpu_ack_i(ack),
		.cpu_ret_i(ret), .cpu_ret_level_i(ret_lvl), .cpu_req_o(req),
		.vec_valid_o(vvalid), .vec_addr_o(vaddr), .vec_loc_o(vloc),
		.vec_num_o(vnum), .cpu_level_o(level), .ret_done_o(rdone),
		.irq_o(irq));
	cpu_model i_cpu (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req),
		.ack_en_i(ack_en_q), .delay_i(dly_q), .ret_go_i(go_q),
		.ret_level_i(lvl_q), .ack_o(ack), .ret_o(ret),
		.ret_level_o(ret_lvl));

	task conclude;
		$display("Compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	task chk(input string what, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task tmo(input logic ok);
		if (ok !== 1'b1)
		begin
			miscompares++;
			conclude();
		end
	endtask : tmo

	task axw(input logic [11:0] a, input logic [31:0] d);
		int n;
		bus_q.awaddr <= a;
		bus_q.wdata <= d;
		bus_q.wstrb <= 4'hF;
		bus_q.awvalid <= 1'b1;
		bus_q.wvalid <= 1'b1;
		n = 0;
		do begin @(posedge clk_i); n++; end
		while (bus_o.awready !== 1'b1 && n < 50);
		tmo(bus_o.awready);
		bus_q.awvalid <= 1'b0;
		bus_q.wvalid <= 1'b0;
		bus_q.bready <= 1'b1;
		n = 0;
		do begin @(posedge clk_i); n++; end
		while (bus_o.bvalid !== 1'b1 && n < 50);
		tmo(bus_o.bvalid);
		chk("bresp", 32'(bus_o.bresp), 32'(RESP_OKAY));
		bus_q.bready <= 1'b0;
	endtask : axw

	task axr(input logic [11:0] a);
		int n;
		bus_q.araddr <= a;
		bus_q.arvalid <= 1'b1;
		n = 0;
		do begin @(posedge clk_i); n++; end
		while (bus_o.arready !== 1'b1 && n < 50);
		tmo(bus_o.arready);
		bus_q.arvalid <= 1'b0;
		bus_q.rready <= 1'b1;
		n = 0;
		do begin @(posedge clk_i); n++; end
		while (bus_o.rvalid !== 1'b1 && n < 50);
		tmo(bus_o.rvalid);
		rd = bus_o.rdata;
		rsp = bus_o.rresp;
		bus_q.rready <= 1'b0;
	endtask : axr

	task rchk(input string what, input logic [11:0] a, input logic [31:0] e);
		axr(a);
		chk(what, rd, e);
	endtask : rchk

	task pulse(input int n, input logic trap);
		if (trap)
			trap_q[n] <= 1'b1;
		else
			src_q[n] <= 1'b1;
		@(posedge clk_i);
		src_q <= '0;
		trap_q <= '0;
		@(posedge clk_i);
	endtask : pulse

	task entry(input logic [6:0] num, input logic [23:0] loc, adr,
		input logic [3:0] lv);
		int n;
		ack_en_q <= 1'b1;
		n = 0;
		do begin @(posedge clk_i); n++; end
		while ((req & ack) !== 1'b1 && n < 100);
		tmo(req & ack);
		ack_en_q <= 1'b0;
		n = 0;
		do begin @(posedge clk_i); n++; end
		while (vvalid !== 1'b1 && n < 10);
		chk("entry cycles", 32'(n), 32'(ENTRY_CYCLES));
		tmo(vvalid);
		chk("vector address", 32'(vaddr), 32'(adr));
		chk("vector number", 32'(vnum), 32'(num));
		chk("table location", 32'(vloc), 32'(loc));
		chk("new level", 32'(level), 32'(lv));
		rchk("latch", LATCH_OFS, {20'h0, lv, 1'b0, num});
	endtask : entry

	task ret_to(input logic [3:0] lv);
		int n;
		go_q <= 1'b1;
		lvl_q <= lv;
		@(posedge clk_i);
		go_q <= 1'b0;
		n = 0;
		do begin @(posedge clk_i); n++; end
		while (ret !== 1'b1 && n < 10);
		tmo(ret);
		n = 0;
		do begin @(posedge clk_i); n++; end
		while (rdone !== 1'b1 && n < 10);
		chk("return cycles", 32'(n), 32'(RET_CYCLES));
		tmo(rdone);
		chk("restored level", 32'(level), 32'(lv));
	endtask : ret_to

	task t_reset;
		chk("req at reset", 32'(req), 32'h0);
		chk("location at reset", 32'(vloc), 32'h0);
		rchk("level at reset", LEVEL_OFS, 32'h0);
		axr(12'h200);
		chk("unmapped resp", 32'(rsp), 32'(RESP_SLVERR));
		axw(LEVEL_OFS, 32'hF);
		rchk("level top bit", LEVEL_OFS, 32'h7);
		axw(LEVEL_OFS, 32'h0);
		axw(12'h420, 32'h0A1000);
		axw(12'h554, 32'h0B2000);
		axw(12'h408, 32'h0C3000);
		axw(12'h620, 32'h0D4000);
	endtask : t_reset

	task t_arbitrate;
		pulse(0, 1'b0);
		pulse(1, 1'b0);
		pulse(4, 1'b0);
		rchk("flag word 0", FLAG_OFS, 32'h3);
		axw(PRIO_OFS, 32'h33);
		chk("req disabled", 32'(req), 32'h0);
		axw(ENABLE_OFS, 32'h3);
		chk("req enabled", 32'(req), 32'h1);
		entry(7'd8, 24'h000014, 24'h0A1000, 4'h3);
		ret_to(4'h0);
		pulse(77, 1'b0);
		rchk("flag word 4", FLAG_OFS + 12'h10, 32'h2000);
		axw(ENABLE_OFS + 12'h10, 32'h2000);
		axw(PRIO_OFS + 12'h4C, 32'h50);
		dly_q <= 4'h5;
		entry(7'd85, 24'h0000AE, 24'h0B2000, 4'h5);
		chk("req below level", 32'(req), 32'h0);
		axw(FLAG_OFS + 12'h10, 32'h0);
		ret_to(4'h2);
		entry(7'd8, 24'h000014, 24'h0A1000, 4'h3);
		axw(FLAG_OFS, 32'h0);
		ret_to(4'h0);
	endtask : t_arbitrate

	task t_trap;
		pulse(0, 1'b1);
		pulse(2, 1'b1);
		rchk("trap status", TRAP_OFS, 32'h4);
		entry(7'd2, 24'h000008, 24'h0C3000, TRAP_LEVEL);
		axw(LEVEL_OFS, 32'h0);
		rchk("trap level kept", LEVEL_OFS, 32'h8);
		axw(TRAP_OFS, 32'h0);
		ret_to(4'h0);
	endtask : t_trap

	task t_alt_irq;
		dly_q <= 4'h0;
		axw(TABSEL_OFS, 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		axw(EVT_MASK_OFS, 32'h1);
		chk("irq raised", 32'(irq), 32'h1);
		axw(EVT_STAT_OFS, 32'h7);
		chk("irq cleared", 32'(irq), 32'h0);
		pulse(0, 1'b0);
		entry(7'd8, 24'h000114, 24'h0D4000, 4'h3);
		chk("irq on entry", 32'(irq), 32'h1);
		axw(EVT_STAT_OFS, 32'h1);
		chk("irq after clear", 32'(irq), 32'h0);
		axw(FLAG_OFS, 32'h0);
		ret_to(4'h0);
	endtask : t_alt_irq

	initial
	begin
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		t_reset();
		t_arbitrate();
		t_trap();
		t_alt_irq();
		conclude();
	end
endmodule : vectored_interrupt_controller_test
